// ### core/host_fifo_pkg.sv
package host_fifo_pkg;

  // ------------------------------------------------------------
  // Widths and depths
  // ------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int LIMIT_W = 5;

  // ------------------------------------------------------------
  // Host address map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] RX_DATA_BASE = 8'h00;
  localparam logic [7:0] TX_DATA_BASE = 8'h40;
  localparam logic [7:0] RX_STS_POP = 8'h80;
  localparam logic [7:0] RX_STS_PEEK = 8'h84;
  localparam logic [7:0] TX_STS_POP = 8'h88;
  localparam logic [7:0] TX_STS_PEEK = 8'h8C;
  localparam logic [7:0] LEVEL_REG = 8'h90;
  localparam logic [7:0] COMMAND_REG = 8'h94;
  localparam logic [7:0] SIZE_REG = 8'h98;
  localparam logic [7:0] EVENT_REG = 8'h9C;
  localparam logic [7:0] KEEP_REG = 8'hA0;

  // Alias windows: 8 dwords in 32-bit mode, 16 dwords in 16-bit mode
  localparam logic [7:0] WIN32_MASK = 8'hE0;
  localparam logic [7:0] WIN16_MASK = 8'hC0;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int SIZE_RXD_LSB = 0;
  localparam int SIZE_RXS_LSB = 8;
  localparam int SIZE_TXD_LSB = 16;
  localparam int LVL_RXD_LSB = 0;
  localparam int LVL_RXS_LSB = 8;
  localparam int LVL_TXD_LSB = 16;
  localparam int LVL_TXS_LSB = 24;
  localparam int CMD_SOFT_RST_BIT = 0;
  localparam int EVT_WOC_BIT = 0;
  localparam int EVT_RC_BIT = 1;
  localparam int EVT_LH_BIT = 2;
  localparam int EVT_LL_BIT = 3;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [LIMIT_W-1:0] LIMIT_RESET = 5'h10;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [DATA_W-1:0] KEEP_RESET = 32'h0000_0000;

endpackage

// ### core/host_fifo_ports.sv
// Functional notes
// - Read-only registers ignore every host write.
// - Write-only registers read back as zero.
// - Write-one-clear bits: writing 1 clears, writing 0 keeps.
// - Read-clears bits are cleared by the host reading them.
// - Latched status bits hold their captured value until read, then return to idle: the latched-high bit clears, the latched-low bit sets.
// - No-soft-reset-effect bits keep their value across a software reset.
// - Hardware reset loads every internal register except queue storage with its default; software reset spares the keep register and pin synchronisers.
// - Four queues; both data and receive status sizes set by control register.
// - Receive data and receive status queues are read-only to host.
// - Receive status pop address returns head and removes it.
// - Receive status peek address returns head without removing it.
// - Every receive data read of a non-empty queue returns the head word and removes it; empty reads return zero.
// - Receive data port aliased over 8 or 16 dword window.
// - Transmit status pop address returns head and removes it.
// - Transmit status peek address returns head and leaves it.
// - Transmit data port is write-only, aliased over 8 or 16 dwords.
`timescale 1ns/1ps

module stream_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int CNT_W = $clog2(DEPTH + 1)
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic flush_i,
  input wire logic [CNT_W-1:0] limit_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i,
  output logic [CNT_W-1:0] level_o
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;

  // Programmed size caps the usable depth
  assign in_ready_o = (count < limit_i) && (count < CNT_W'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  assign level_o = count;

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i || flush_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + CNT_W'(push) - CNT_W'(pop);
    end
  end
endmodule

module host_fifo_ports #(
  parameter int DEPTH = host_fifo_pkg::FIFO_DEPTH
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic soft_rst_i,
  input wire logic bus16_mode_i,
  input wire logic host_rd_i,
  input wire logic host_wr_i,
  input wire logic [host_fifo_pkg::ADDR_W-1:0] host_addr_i,
  input wire logic [host_fifo_pkg::DATA_W-1:0] host_wdata_i,
  output logic [host_fifo_pkg::DATA_W-1:0] host_rdata_o,
  output logic host_rdata_valid_o,
  input wire logic rx_data_valid_i,
  input wire logic [host_fifo_pkg::DATA_W-1:0] rx_data_i,
  output logic rx_data_ready_o,
  input wire logic rx_sts_valid_i,
  input wire logic [host_fifo_pkg::DATA_W-1:0] rx_sts_i,
  input wire logic tx_sts_valid_i,
  input wire logic [host_fifo_pkg::DATA_W-1:0] tx_sts_i,
  output logic tx_sts_ready_o,
  output logic tx_data_valid_o,
  output logic [host_fifo_pkg::DATA_W-1:0] tx_data_o,
  input wire logic tx_data_ready_i,
  input wire logic error_evt_i,
  input wire logic link_up_i,
  output logic soft_rst_o
);
  import host_fifo_pkg::*;

  localparam int CNT_W = $clog2(DEPTH + 1);

  // ------------------------------------------------------------
  // Host pin synchronisers
  // ------------------------------------------------------------
  logic rd_s1, rd_s2, rd_s3;
  logic wr_s1, wr_s2, wr_s3;
  logic b16_s1, b16_s2;
  logic [ADDR_W-1:0] addr_s1, addr_s2;
  logic [DATA_W-1:0] wdata_s1, wdata_s2;

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      rd_s1 <= 1'b0;
      rd_s2 <= 1'b0;
      rd_s3 <= 1'b0;
      wr_s1 <= 1'b0;
      wr_s2 <= 1'b0;
      wr_s3 <= 1'b0;
      b16_s1 <= 1'b0;
      b16_s2 <= 1'b0;
      addr_s1 <= '0;
      addr_s2 <= '0;
      wdata_s1 <= '0;
      wdata_s2 <= '0;
    end else begin
      rd_s1 <= host_rd_i;
      rd_s2 <= rd_s1;
      rd_s3 <= rd_s2;
      wr_s1 <= host_wr_i;
      wr_s2 <= wr_s1;
      wr_s3 <= wr_s2;
      b16_s1 <= bus16_mode_i;
      b16_s2 <= b16_s1;
      addr_s1 <= host_addr_i;
      addr_s2 <= addr_s1;
      wdata_s1 <= host_wdata_i;
      wdata_s2 <= wdata_s1;
    end
  end

  // One access per strobe, counted on its rising edge
  wire rd_evt = rd_s2 && !rd_s3;
  wire wr_evt = wr_s2 && !wr_s3;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  function automatic logic in_window(input logic [7:0] a, input logic [7:0] base, input logic b16);
    in_window = b16 ? ((a & WIN16_MASK) == base) : ((a & WIN32_MASK) == base);
  endfunction

  wire hit_rxd = in_window(addr_s2, RX_DATA_BASE, b16_s2);
  wire hit_txd = in_window(addr_s2, TX_DATA_BASE, b16_s2);
  wire hit_rxs_pop = (addr_s2 == RX_STS_POP);
  wire hit_rxs_peek = (addr_s2 == RX_STS_PEEK);
  wire hit_txs_pop = (addr_s2 == TX_STS_POP);
  wire hit_txs_peek = (addr_s2 == TX_STS_PEEK);
  wire hit_level = (addr_s2 == LEVEL_REG);
  wire hit_cmd = (addr_s2 == COMMAND_REG);
  wire hit_size = (addr_s2 == SIZE_REG);
  wire hit_event = (addr_s2 == EVENT_REG);
  wire hit_keep = (addr_s2 == KEEP_REG);

  // ------------------------------------------------------------
  // Software reset
  // ------------------------------------------------------------
  // Command write is self-clearing; it lasts one cycle
  wire cmd_soft = wr_evt && hit_cmd && wdata_s2[CMD_SOFT_RST_BIT];
  wire soft_any = soft_rst_i || cmd_soft;
  wire sys_rst_b = rst_b_i && !soft_any;
  assign soft_rst_o = soft_any;

  // ------------------------------------------------------------
  // Queues
  // ------------------------------------------------------------
  logic [LIMIT_W-1:0] rxd_limit, rxs_limit, txd_limit;
  logic [CNT_W-1:0] rxd_lvl, rxs_lvl, txd_lvl, txs_lvl;
  logic rxd_out_valid, rxs_out_valid, txs_out_valid;
  logic [DATA_W-1:0] rxd_head, rxs_head, txs_head;
  logic rxs_in_ready, txd_in_ready;

  // Pops only on a read of a non-empty queue; empty reads return zero
  wire rxd_pop = rd_evt && hit_rxd;
  wire rxs_pop = rd_evt && hit_rxs_pop;
  wire txs_pop = rd_evt && hit_txs_pop;
  wire txd_push = wr_evt && hit_txd;

  stream_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) rxd_fifo (
    .mclk_i(mclk_i),
    .rst_b_i(sys_rst_b),
    .flush_i(1'b0),
    .limit_i(CNT_W'(rxd_limit)),
    .in_valid_i(rx_data_valid_i),
    .in_data_i(rx_data_i),
    .in_ready_o(rx_data_ready_o),
    .out_valid_o(rxd_out_valid),
    .out_data_o(rxd_head),
    .out_ready_i(rxd_pop),
    .level_o(rxd_lvl)
  );

  stream_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) rxs_fifo (
    .mclk_i(mclk_i),
    .rst_b_i(sys_rst_b),
    .flush_i(1'b0),
    .limit_i(CNT_W'(rxs_limit)),
    .in_valid_i(rx_sts_valid_i),
    .in_data_i(rx_sts_i),
    .in_ready_o(rxs_in_ready),
    .out_valid_o(rxs_out_valid),
    .out_data_o(rxs_head),
    .out_ready_i(rxs_pop),
    .level_o(rxs_lvl)
  );

  stream_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) txs_fifo (
    .mclk_i(mclk_i),
    .rst_b_i(sys_rst_b),
    .flush_i(1'b0),
    .limit_i(CNT_W'(DEPTH)),
    .in_valid_i(tx_sts_valid_i),
    .in_data_i(tx_sts_i),
    .in_ready_o(tx_sts_ready_o),
    .out_valid_o(txs_out_valid),
    .out_data_o(txs_head),
    .out_ready_i(txs_pop),
    .level_o(txs_lvl)
  );

  // Host cannot be stalled; a write into a full queue is lost and flagged
  stream_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) txd_fifo (
    .mclk_i(mclk_i),
    .rst_b_i(sys_rst_b),
    .flush_i(1'b0),
    .limit_i(CNT_W'(txd_limit)),
    .in_valid_i(txd_push),
    .in_data_i(wdata_s2),
    .in_ready_o(txd_in_ready),
    .out_valid_o(tx_data_valid_o),
    .out_data_o(tx_data_o),
    .out_ready_i(tx_data_ready_i),
    .level_o(txd_lvl)
  );

  // ------------------------------------------------------------
  // Size control register
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!sys_rst_b) begin
      rxd_limit <= LIMIT_RESET;
      rxs_limit <= LIMIT_RESET;
      txd_limit <= LIMIT_RESET;
    end else if (wr_evt && hit_size) begin
      rxd_limit <= wdata_s2[SIZE_RXD_LSB +: LIMIT_W];
      rxs_limit <= wdata_s2[SIZE_RXS_LSB +: LIMIT_W];
      txd_limit <= wdata_s2[SIZE_TXD_LSB +: LIMIT_W];
    end
  end

  // ------------------------------------------------------------
  // Register kept through software reset
  // ------------------------------------------------------------
  logic [DATA_W-1:0] keep_reg;

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      keep_reg <= KEEP_RESET;
    end else if (wr_evt && hit_keep) begin
      keep_reg <= wdata_s2;
    end
  end

  // ------------------------------------------------------------
  // Event register
  // ------------------------------------------------------------
  logic evt_woc, evt_rc, evt_lh, evt_ll;
  wire evt_read = rd_evt && hit_event;
  wire set_woc = rx_sts_valid_i && !rxs_in_ready;
  wire set_rc = txd_push && !txd_in_ready;

  always_ff @(posedge mclk_i) begin
    if (!sys_rst_b) begin
      evt_woc <= 1'b0;
      evt_rc <= 1'b0;
      evt_lh <= 1'b0;
      evt_ll <= 1'b1;
    end else begin
      // Set beats clear so no event is lost
      if (set_woc) begin
        evt_woc <= 1'b1;
      end else if (wr_evt && hit_event && wdata_s2[EVT_WOC_BIT]) begin
        evt_woc <= 1'b0;
      end
      if (set_rc) begin
        evt_rc <= 1'b1;
      end else if (evt_read) begin
        evt_rc <= 1'b0;
      end
      if (error_evt_i) begin
        evt_lh <= 1'b1;
      end else if (evt_read) begin
        evt_lh <= 1'b0;
      end
      if (!link_up_i) begin
        evt_ll <= 1'b0;
      end else if (evt_read) begin
        evt_ll <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // Writes to the level register and queue read ports have no decode path
  wire [DATA_W-1:0] level_word = (DATA_W'(rxd_lvl) << LVL_RXD_LSB) | (DATA_W'(rxs_lvl) << LVL_RXS_LSB)
                               | (DATA_W'(txd_lvl) << LVL_TXD_LSB) | (DATA_W'(txs_lvl) << LVL_TXS_LSB);
  wire [DATA_W-1:0] size_word = (DATA_W'(rxd_limit) << SIZE_RXD_LSB) | (DATA_W'(rxs_limit) << SIZE_RXS_LSB)
                              | (DATA_W'(txd_limit) << SIZE_TXD_LSB);
  wire [DATA_W-1:0] event_word = (DATA_W'(evt_woc) << EVT_WOC_BIT) | (DATA_W'(evt_rc) << EVT_RC_BIT)
                               | (DATA_W'(evt_lh) << EVT_LH_BIT) | (DATA_W'(evt_ll) << EVT_LL_BIT);
  wire [DATA_W-1:0] rxd_word = rxd_out_valid ? rxd_head : ZERO_WORD;
  wire [DATA_W-1:0] rxs_word = rxs_out_valid ? rxs_head : ZERO_WORD;
  wire [DATA_W-1:0] txs_word = txs_out_valid ? txs_head : ZERO_WORD;

  // Write-only ports, command and unmapped addresses read as zero
  wire [DATA_W-1:0] next_rdata =
    hit_rxd ? rxd_word :
    (hit_rxs_pop || hit_rxs_peek) ? rxs_word :
    (hit_txs_pop || hit_txs_peek) ? txs_word :
    hit_level ? level_word :
    hit_size ? size_word :
    hit_event ? event_word :
    hit_keep ? keep_reg :
    ZERO_WORD;

  always_ff @(posedge mclk_i) begin
    if (!sys_rst_b) begin
      host_rdata_o <= ZERO_WORD;
      host_rdata_valid_o <= 1'b0;
    end else begin
      host_rdata_valid_o <= rd_evt;
      if (rd_evt) begin
        host_rdata_o <= next_rdata;
      end
    end
  end
endmodule

// ### verif/host_fifo_ports_props.sv
`timescale 1ns/1ps
module host_fifo_ports_props
  import host_fifo_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic soft_rst_i,
  input wire logic host_rd_i,
  input wire logic host_wr_i,
  input wire logic [ADDR_W-1:0] host_addr_i,
  input wire logic [DATA_W-1:0] host_rdata_o,
  input wire logic host_rdata_valid_o,
  input wire logic rx_data_ready_o,
  input wire logic tx_sts_ready_o,
  input wire logic tx_data_valid_o,
  input wire logic [DATA_W-1:0] tx_data_o,
  input wire logic tx_data_ready_i,
  input wire logic soft_rst_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);
  // ----------------
  // Read handshake
  // ----------------
  sequence s_rd_start;
    $rose(host_rd_i);
  endsequence
  sequence s_answer;
    ##[2:6] host_rdata_valid_o;
  endsequence
  sequence s_zero_answer;
    ##[2:6] host_rdata_valid_o && host_rdata_o == ZERO_WORD;
  endsequence
  a_read_answered: assert property (s_rd_start |-> s_answer) else $error("read unanswered");
  a_wo_reads_zero: assert property ($rose(host_rd_i) && host_addr_i == COMMAND_REG |-> s_zero_answer)
    else $error("command read not zero");
  a_valid_pulse: assert property (host_rdata_valid_o |=> !host_rdata_valid_o) else $error("valid too long");
  a_valid_in_read: assert property (host_rdata_valid_o |-> host_rd_i) else $error("valid without read");
  a_rdata_holds: assert property (disable iff (!rst_b_i || soft_rst_o)
    !host_rdata_valid_o && !$past(soft_rst_o) |-> $stable(host_rdata_o)) else $error("rdata moved");
  a_write_quiet: assert property ($rose(host_wr_i) |-> !host_rdata_valid_o [*6]) else $error("write answered");
  // ----------------
  // Resets and streams
  // ----------------
  a_reset_state: assert property ($rose(rst_b_i) |-> !host_rdata_valid_o && !tx_data_valid_o
    && rx_data_ready_o && tx_sts_ready_o && host_rdata_o == ZERO_WORD) else $error("bad reset state");
  a_soft_follows: assert property (soft_rst_i |-> soft_rst_o) else $error("soft reset lost");
  a_soft_empties: assert property (soft_rst_o |=> !tx_data_valid_o && rx_data_ready_o && tx_sts_ready_o)
    else $error("queues kept");
  a_tx_held: assert property (disable iff (!rst_b_i || soft_rst_o)
    tx_data_valid_o && !tx_data_ready_i |=> tx_data_valid_o && $stable(tx_data_o)) else $error("tx dropped");
endmodule

// ### verif/host_model.sv
`timescale 1ns/1ps
module host_model
  import host_fifo_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rdata_valid_i,
  output logic rd_o,
  output logic wr_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] wdata_o
);
  initial begin
    {rd_o, wr_o} = 2'b00;
    addr_o = '0;
    wdata_o = '0;
  end
  // ----------------
  // One access; slow stretches setup, strobe and idle
  // ----------------
  task automatic access(input logic is_rd, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        input int slow);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    @(posedge mclk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    repeat (3 + slow) @(posedge mclk_i);
    #1;
    rd_o = is_rd;
    wr_o = !is_rd;
    do begin
      @(posedge mclk_i);
      #1;
      n++;
      // Answer pulse lasts one cycle, so remember it once seen
      if (rdata_valid_i === 1'b1) got = 1'b1;
    end while (n < 4 + slow || (is_rd && !got && n < 20));
    @(posedge mclk_i);
    #1;
    {rd_o, wr_o} = 2'b00;
    @(posedge mclk_i);
    #1;
    // Released bus must not keep looking valid
    addr_o = ~a;
    wdata_o = ~d;
    repeat (2 + slow) @(posedge mclk_i);
    #1;
  endtask
endmodule

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import host_fifo_pkg::*;
  localparam logic [31:0] SIZE_DEF = 32'h0010_1010;
  logic mclk, rst_b, soft_rst, bus16, rd, wr, rdv, rx_dv, rx_dr, rx_sv, tx_sv, tx_sr, tx_dv, tx_dr, err, link, soft_o;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, rx_d, rx_s, tx_s, tx_d, w, k;
  logic [DATA_W-1:0] exp_q[$];
  logic [DATA_W-1:0] tx_q[$];
  logic [DATA_W-1:0] words[16];
  int failures;
  int num_checks;
  host_fifo_ports i_host_fifo_ports (.mclk_i(mclk), .rst_b_i(rst_b), .soft_rst_i(soft_rst), .bus16_mode_i(bus16),
    .host_rd_i(rd), .host_wr_i(wr), .host_addr_i(addr), .host_wdata_i(wdata), .host_rdata_o(rdata),
    .host_rdata_valid_o(rdv), .rx_data_valid_i(rx_dv), .rx_data_i(rx_d), .rx_data_ready_o(rx_dr),
    .rx_sts_valid_i(rx_sv), .rx_sts_i(rx_s), .tx_sts_valid_i(tx_sv), .tx_sts_i(tx_s), .tx_sts_ready_o(tx_sr),
    .tx_data_valid_o(tx_dv), .tx_data_o(tx_d), .tx_data_ready_i(tx_dr), .error_evt_i(err), .link_up_i(link),
    .soft_rst_o(soft_o));
  host_model i_host_model (.mclk_i(mclk), .rdata_valid_i(rdv), .rd_o(rd), .wr_o(wr), .addr_o(addr),
    .wdata_o(wdata));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic rd_exp(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    exp_q.push_back(e);
    i_host_model.access(1'b1, a, $urandom, $urandom_range(1, 0));
  endtask
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    i_host_model.access(1'b0, a, d, $urandom_range(1, 0));
  endtask
  // Queue 0 rx data, 1 rx status (no ready), 2 tx status
  task automatic push(input int q, input logic [DATA_W-1:0] v);
    int n;
    n = 0;
    {rx_d, rx_s, tx_s} = {v, v, v};
    {rx_dv, rx_sv, tx_sv} = {q == 0, q == 1, q == 2};
    do begin
      @(posedge mclk);
      n++;
    end while (q != 1 && (q == 0 ? rx_dr : tx_sr) !== 1'b1 && n < 40);
    #1;
    {rx_dv, rx_sv, tx_sv} = 3'b000;
    {rx_d, rx_s, tx_s} = {~v, ~v, ~v};
    @(posedge mclk);
    #1;
  endtask
  // ----------------
  // Result monitor
  // ----------------
  always @(posedge mclk) begin
    if (rdv === 1'b1) check(rdata, exp_q.size() ? exp_q.pop_front() : ~rdata);
    if (tx_dv === 1'b1 && tx_dr === 1'b1) check(tx_d, tx_q.size() ? tx_q.pop_front() : ~tx_d);
  end
  initial begin
    repeat (30000) @(posedge mclk);
    failures++;
    $display("MISMATCH %0t watchdog", $time);
    end_sim();
  end
  initial begin
    {rst_b, soft_rst, bus16, rx_dv, rx_sv, tx_sv, tx_dr, err, link} = 9'b0_0000_0001;
    {rx_d, rx_s, tx_s} = '0;
    void'($urandom(32'h66cbdc5a));
    repeat (5) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    rd_exp(LEVEL_REG, ZERO_WORD);
    rd_exp(SIZE_REG, SIZE_DEF);
    rd_exp(EVENT_REG, 32'h0000_0008);
    rd_exp(COMMAND_REG, ZERO_WORD);
    wr_reg(LEVEL_REG, 32'hFFFF_FFFF);
    wr_reg(RX_DATA_BASE, 32'h1234_5678);
    rd_exp(LEVEL_REG, ZERO_WORD);
    $display("reset and access kinds done");
    for (int m = 0; m < 2; m++) begin
      bus16 = m[0];
      for (int i = 0; i < 8 + 8 * m; i++) begin
        words[i] = $urandom;
        push(0, words[i]);
      end
      if (m == 1) check(32'(rx_dr), ZERO_WORD);
      for (int i = 0; i < 8 + 8 * m; i++) rd_exp(RX_DATA_BASE + 8'(4 * i), words[i]);
    end
    rd_exp(RX_DATA_BASE, ZERO_WORD);
    $display("rx data aliases done");
    for (int q = 1; q < 3; q++) begin
      words[0] = $urandom;
      words[1] = $urandom;
      push(q, words[0]);
      push(q, words[1]);
      for (int j = 0; j < 5; j++) begin
        rd_exp((q == 1 ? RX_STS_POP : TX_STS_POP) + ((j % 2 == 0) ? 8'h04 : 8'h00),
          (j < 4) ? words[j / 2] : ZERO_WORD);
      end
      rd_exp(q == 1 ? RX_STS_POP : TX_STS_POP, ZERO_WORD);
    end
    $display("status peek and pop done");
    bus16 = 1'b0;
    for (int i = 0; i < 17; i++) begin
      w = $urandom;
      if (i < 16) tx_q.push_back(w);
      wr_reg(TX_DATA_BASE + 8'(4 * (i % 8)), w);
    end
    rd_exp(LEVEL_REG, 32'h0010_0000);
    rd_exp(EVENT_REG, 32'h0000_000A);
    rd_exp(EVENT_REG, 32'h0000_0008);
    repeat (80) begin
      @(posedge mclk);
      #1;
      tx_dr = $urandom_range(1, 0);
    end
    @(posedge mclk);
    #1;
    tx_dr = 1'b0;
    check(32'(tx_q.size()), ZERO_WORD);
    $display("tx fill and drain done");
    for (int i = 0; i < 17; i++) push(1, 32'(i));
    rd_exp(EVENT_REG, 32'h0000_0009);
    wr_reg(EVENT_REG, ZERO_WORD);
    rd_exp(EVENT_REG, 32'h0000_0009);
    wr_reg(EVENT_REG, 32'h0000_0001);
    rd_exp(EVENT_REG, 32'h0000_0008);
    for (int i = 0; i < 16; i++) rd_exp(RX_STS_POP, 32'(i));
    err = 1'b1;
    link = 1'b0;
    @(posedge mclk);
    #1;
    {err, link} = 2'b01;
    rd_exp(EVENT_REG, 32'h0000_0004);
    rd_exp(EVENT_REG, 32'h0000_0008);
    $display("event bits done");
    k = $urandom;
    wr_reg(KEEP_REG, k);
    wr_reg(SIZE_REG, 32'h0010_1002);
    push(0, k);
    push(0, ~k);
    check(32'(rx_dr), ZERO_WORD);
    wr_reg(COMMAND_REG, 32'h0000_0001);
    rd_exp(SIZE_REG, SIZE_DEF);
    rd_exp(LEVEL_REG, ZERO_WORD);
    rd_exp(KEEP_REG, k);
    soft_rst = 1'b1;
    #1;
    check(32'(soft_o), 32'h0000_0001);
    @(posedge mclk);
    #1;
    soft_rst = 1'b0;
    rd_exp(KEEP_REG, k);
    rd_exp(EVENT_REG, 32'h0000_0008);
    $display("soft reset done");
    check(32'(exp_q.size()), ZERO_WORD);
    check(32'(tx_q.size()), ZERO_WORD);
    end_sim();
  end
endmodule
bind host_fifo_ports host_fifo_ports_props i_host_fifo_ports_props (.*);
